// ---- src/aab_pkg.sv ----
// Shared constants and types for the accumulator add and bit-operation datapath
package aab_pkg;
   localparam int        DATA_W      = 8;
   localparam int        ADDR_W      = 7;
   localparam int        BIT_SEL_W   = 3;
   localparam int        CARRY_POS   = 8;   // Carry out of bit 7 sits at sum bit 8
   localparam int        DC_POS      = 4;   // Carry out of bit 3 sits at nibble sum bit 4
   localparam logic [6:0] IO_ADDR_DEF = 7'h7f; // Pin-backed register address, arbitrary default
   localparam logic [7:0] W_RST      = 8'h00;
   localparam logic [7:0] BIT_ONE    = 8'h01;
   localparam logic [7:0] ZERO_BYTE  = 8'h00;

   typedef enum logic [3:0] {
      NO_OPERATION,
      ADD_LITERAL_OP,
      ADD_REGISTER_OP,
      AND_LITERAL_OP,
      AND_REGISTER_OP,
      BIT_CLEAR_OP,
      BIT_SET_OP,
      SKIP_IF_BIT_CLEAR_OP,
      SKIP_IF_BIT_SET_OP
   } aab_op_type;
endpackage : aab_pkg

// ---- src/aab_alu_if.sv ----
// Operand and result bundle between the execution core and its arithmetic unit
interface aab_alu_if;
   import aab_pkg::*;
   aab_op_type     op;
   logic [7:0]     acc;       // Accumulator operand
   logic [7:0]     opnd;      // Literal or file register operand
   logic [2:0]     bit_sel;
   logic [7:0]     result;
   logic           carry;
   logic           digit_carry;
   logic           zero;
   logic           bit_val;   // Selected bit of the operand

   modport alu  (input op, acc, opnd, bit_sel,
                 output result, carry, digit_carry, zero, bit_val);
   modport core (output op, acc, opnd, bit_sel,
                 input result, carry, digit_carry, zero, bit_val);
endinterface : aab_alu_if

// ---- src/aab_alu.sv ----
// Combinational adder, AND unit and bit modifier
module aab_alu
   import aab_pkg::*;
(
   aab_alu_if.alu  u   // Operands in, result and flags out
);
   wire logic [8:0] sum9;
   wire logic [4:0] sum5;
   wire logic [7:0] mask;

   assign sum9 = {1'b0, u.acc} + {1'b0, u.opnd};
   assign sum5 = {1'b0, u.acc[3:0]} + {1'b0, u.opnd[3:0]};
   assign mask = BIT_ONE << u.bit_sel;

   assign u.carry       = sum9[CARRY_POS];  // [RULE12]
   assign u.digit_carry = sum5[DC_POS];     // [RULE12]
   assign u.zero        = (u.result == ZERO_BYTE); // [RULE12]
   assign u.bit_val     = u.opnd[u.bit_sel];

   always_comb begin
      case (u.op)
         ADD_LITERAL_OP, ADD_REGISTER_OP: u.result = sum9[7:0];   // [RULE1] [RULE2]
         AND_LITERAL_OP, AND_REGISTER_OP: u.result = u.acc & u.opnd; // [RULE4] [RULE5]
         BIT_CLEAR_OP:    u.result = u.opnd & ~mask;   // [RULE6] [RULE13]
         BIT_SET_OP:      u.result = u.opnd | mask;    // [RULE7] [RULE13]
         default:         u.result = u.opnd;
      endcase
   end
endmodule : aab_alu

// ---- src/aab_exec.sv ----
// Execution core: add, AND, bit set/clear and bit-test-and-skip
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RULE1] Literal add puts accumulator plus literal into accumulator, updating C, DC, Z.
// [RULE2] Register add sums accumulator and addressed file register, updating C, DC, Z.
// [RULE3] Destination 0 writes the accumulator, destination 1 writes the file register.
// [RULE4] Literal AND puts accumulator AND literal into accumulator, only Z changes.
// [RULE5] Register AND routes by destination bit and changes only Z.
// [RULE6] Bit clear forces the selected bit low, flags untouched.
// [RULE7] Bit set forces the selected bit high, flags untouched.
// [RULE8] Skip-if-clear on a zero bit discards the next instruction, two cycles.
// [RULE9] Skip-if-set on a one bit discards the next instruction, two cycles.
// [RULE10] A successful test costs a second cycle run as a no-operation.
// [RULE11] Pin-backed register used as its own source reads the pin levels.
// [RULE12] Z marks a zero result, C carry from bit 7, DC carry from bit 3.
// [RULE13] Bit operations rewrite the whole register, other bits as read.
module aab_exec
   import aab_pkg::*;
#(
   parameter int          P_DATA_W  = DATA_W,
   parameter int          P_ADDR_W  = ADDR_W,
   parameter logic [6:0]  IO_ADDR   = IO_ADDR_DEF
)(
   input  wire logic        mclk_i,           // Instruction clock, 40 MHz
   input  wire logic        rst_i,            // Asynchronous reset, active high
   input  wire logic        valid_i,          // Decoded instruction present
   input  aab_op_type       op_i,             // Decoded operation
   input  wire logic [7:0]  literal_i,        // Eight-bit literal
   input  wire logic [6:0]  addr_i,           // File register address
   input  wire logic        dest_i,           // 0 accumulator, 1 file register
   input  wire logic [2:0]  bit_sel_i,        // Bit position
   input  wire logic [7:0]  file_rdata_i,     // File register contents at addr_i
   input  wire logic [7:0]  pin_level_i,      // Asynchronous pin levels
   output logic [7:0]       w_o,              // Accumulator
   output logic             carry_o,          // Carry flag
   output logic             digit_carry_flag_o, // Digit carry flag
   output logic             zero_o,           // Zero flag
   output logic             wr_en_o,          // File register write pulse
   output logic [6:0]       wr_addr_o,        // File register write address
   output logic [7:0]       wr_data_o,        // File register write data
   output logic             skip_o            // No-operation cycle in progress
);
   // Refused at elaboration: the adder taps and flag positions are fixed at these widths
   if (P_DATA_W != DATA_W || P_ADDR_W != ADDR_W) begin : g_width_check
      $error("aab_exec serves only 8-bit data and 7-bit addresses");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser
   logic [7:0] pin_meta_reg;
   logic [7:0] pin_sync_reg;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_meta_reg <= ZERO_BYTE;
         pin_sync_reg <= ZERO_BYTE;
      end else begin
         pin_meta_reg <= pin_level_i;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operand selection and decode
   logic [7:0] w_reg;
   logic       carry_reg;
   logic       dc_reg;
   logic       zero_reg;
   logic       wr_en_reg;
   logic [6:0] wr_addr_reg;
   logic [7:0] wr_data_reg;
   logic       skip_reg;

   aab_alu_if alu_bus ();

   wire logic       accept;
   wire logic       is_io;
   wire logic [7:0] src;
   wire logic       is_lit;
   wire logic       is_add;
   wire logic       is_and;
   wire logic       is_bitmod;
   wire logic       is_reg_alu;
   wire logic       to_file;
   wire logic       to_w;
   wire logic       skip_hit;

   // The slot after a successful test is swallowed here, so the sequencer
   // needs no squash logic of its own
   assign accept     = valid_i && !skip_reg;                              // [RULE10]
   assign is_io      = (addr_i == IO_ADDR);
   assign src        = is_io ? pin_sync_reg : file_rdata_i;               // [RULE11]
   assign is_lit     = (op_i == ADD_LITERAL_OP) || (op_i == AND_LITERAL_OP);
   assign is_add     = (op_i == ADD_LITERAL_OP) || (op_i == ADD_REGISTER_OP);
   assign is_and     = (op_i == AND_LITERAL_OP) || (op_i == AND_REGISTER_OP);
   assign is_bitmod  = (op_i == BIT_CLEAR_OP) || (op_i == BIT_SET_OP);
   assign is_reg_alu = (op_i == ADD_REGISTER_OP) || (op_i == AND_REGISTER_OP);
   assign to_file    = accept && ((is_reg_alu && dest_i) || is_bitmod);   // [RULE3]
   assign to_w       = accept && (is_lit || (is_reg_alu && !dest_i));     // [RULE3]
   assign skip_hit   = accept &&
                       (((op_i == SKIP_IF_BIT_CLEAR_OP) && !alu_bus.bit_val) ||  // [RULE8]
                        ((op_i == SKIP_IF_BIT_SET_OP) && alu_bus.bit_val));      // [RULE9]

   assign alu_bus.op      = op_i;
   assign alu_bus.acc     = w_reg;
   assign alu_bus.opnd    = is_lit ? literal_i : src;
   assign alu_bus.bit_sel = bit_sel_i;

   aab_alu u_alu (
      .u (alu_bus.alu)
   );

   ////////////////////////////////////////////////////////////////////////////
   // State update
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         w_reg <= W_RST;
      end else if (to_w) begin
         w_reg <= alu_bus.result;                    // [RULE1] [RULE4]
      end
   end

   // Bit operations and skips never reach the flags
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         carry_reg <= 1'b0;
         dc_reg    <= 1'b0;
         zero_reg  <= 1'b0;
      end else if (accept && (is_add || is_and)) begin
         zero_reg <= alu_bus.zero;                   // [RULE12]
         if (is_add) begin
            carry_reg <= alu_bus.carry;              // [RULE2] [RULE12]
            dc_reg    <= alu_bus.digit_carry;        // [RULE2] [RULE12]
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_en_reg   <= 1'b0;
         wr_addr_reg <= '0;
         wr_data_reg <= ZERO_BYTE;
         skip_reg    <= 1'b0;
      end else begin
         wr_en_reg <= to_file;                       // [RULE3] [RULE13]
         skip_reg  <= skip_hit;                      // [RULE8] [RULE9]
         if (to_file) begin
            wr_addr_reg <= addr_i;
            wr_data_reg <= alu_bus.result;           // [RULE5] [RULE6] [RULE7]
         end
      end
   end

   assign w_o                = w_reg;
   assign carry_o            = carry_reg;
   assign digit_carry_flag_o = dc_reg;
   assign zero_o             = zero_reg;
   assign wr_en_o            = wr_en_reg;
   assign wr_addr_o          = wr_addr_reg;
   assign wr_data_o          = wr_data_reg;
   assign skip_o             = skip_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   wire logic [7:0] chk_mask;
   wire logic [7:0] chk_opnd;
   wire logic [8:0] chk_sum9;
   wire logic [4:0] chk_sum5;
   assign chk_mask = BIT_ONE << bit_sel_i;
   // Checks rebuild the sums here so they do not lean on the unit under test
   assign chk_opnd = is_lit ? literal_i : src;
   assign chk_sum9 = {1'b0, w_reg} + {1'b0, chk_opnd};
   assign chk_sum5 = {1'b0, w_reg[3:0]} + {1'b0, chk_opnd[3:0]};

   a_add_lit_sum: assert property (accept && op_i == ADD_LITERAL_OP |=> // [RULE1]
      w_reg == $past(8'(w_reg + literal_i)) && !wr_en_o)
      else $error("literal add result wrong");
   a_add_reg_dest: assert property (accept && op_i == ADD_REGISTER_OP && dest_i |=> // [RULE2]
      wr_en_o && wr_data_o == $past(8'(w_reg + src)) && $stable(w_reg))
      else $error("register add to file wrong");
   a_dest_w_route: assert property (accept && is_reg_alu && !dest_i |=> // [RULE3]
      !wr_en_o && w_reg == $past(is_add ? chk_sum9[7:0] : (w_reg & chk_opnd)))
      else $error("destination 0 not routed to accumulator");
   a_and_lit_flags: assert property (accept && op_i == AND_LITERAL_OP |=> // [RULE4]
      $stable(carry_reg) && $stable(dc_reg) && zero_reg == (w_reg == ZERO_BYTE))
      else $error("literal AND flags wrong");
   a_and_reg_file: assert property (accept && op_i == AND_REGISTER_OP && dest_i |=> // [RULE5]
      wr_data_o == $past(w_reg & src) && $stable(carry_reg))
      else $error("register AND wrong");
   a_bit_clear_rmw: assert property (accept && op_i == BIT_CLEAR_OP |=> // [RULE6]
      wr_en_o && wr_data_o == $past(src & ~chk_mask) && $stable(zero_reg))
      else $error("bit clear wrong");
   a_bit_set_rmw: assert property (accept && op_i == BIT_SET_OP |=> // [RULE7]
      wr_data_o == $past(src | chk_mask) && $stable(carry_reg) && $stable(zero_reg))
      else $error("bit set wrong");
   a_skip_clr_two: assert property (accept && op_i == SKIP_IF_BIT_CLEAR_OP && // [RULE8]
      !src[bit_sel_i] |=> skip_o ##1 !skip_o)
      else $error("skip on clear bit missing");
   a_skip_set_two: assert property (accept && op_i == SKIP_IF_BIT_SET_OP && // [RULE9]
      src[bit_sel_i] |=> skip_o ##1 !skip_o)
      else $error("skip on set bit missing");
   a_skip_slot_idle: assert property (skip_o |=> !wr_en_o && $stable(w_reg) && // [RULE10]
      $stable(zero_reg))
      else $error("discarded instruction had an effect");
   a_io_pin_source: assert property (accept && is_io && is_bitmod |=> // [RULE11]
      ($past(op_i) == BIT_SET_OP) ? wr_data_o == $past(pin_sync_reg | chk_mask)
                                  : wr_data_o == $past(pin_sync_reg & ~chk_mask))
      else $error("pin register not read from pins");
   a_add_carries: assert property (accept && is_add |=> // [RULE12]
      carry_reg == $past(chk_sum9[CARRY_POS]) && dc_reg == $past(chk_sum5[DC_POS]))
      else $error("add carries wrong");
   a_add_zero_flag: assert property (accept && is_add |=> // [RULE12]
      zero_reg == $past(chk_sum9[7:0] == ZERO_BYTE))
      else $error("add zero flag wrong");
   a_skip_flags_kept: assert property (accept && // [RULE8]
      (op_i == SKIP_IF_BIT_CLEAR_OP || op_i == SKIP_IF_BIT_SET_OP) |=>
      !wr_en_o && $stable(w_reg) && $stable(carry_reg) && $stable(dc_reg) && $stable(zero_reg))
      else $error("bit test changed state");
   a_nop_no_effect: assert property (accept && op_i == NO_OPERATION |=> // [RULE10]
      !wr_en_o && !skip_o && $stable(w_reg) && $stable(zero_reg) && $stable(carry_reg))
      else $error("no-operation had an effect");

   c_add_carry: cover property (accept && is_add ##1 carry_reg);
   c_skip_taken: cover property (skip_hit ##1 valid_i);
   c_io_bitmod: cover property (accept && is_io && is_bitmod);
   c_zero_and: cover property (accept && is_and ##1 zero_reg);
   c_skip_set: cover property (accept && op_i == SKIP_IF_BIT_SET_OP && src[bit_sel_i]);
endmodule : aab_exec

// ---- test/tb_top.sv ----
// Self-checking bench for the accumulator add and bit-operation execution core
module tb_top
   import aab_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      aab_op_type op;
      logic [7:0] k;
      logic [6:0] a;
      logic       d;
      logic [2:0] b;
      logic [7:0] f;
      logic [7:0] res;
   } aab_row_type;

   logic       mclk_i, rst_i = 1'b1, valid_i = 1'b0, dest_i = 1'b0;
   aab_op_type op_i = NO_OPERATION;
   logic [7:0] literal_i = 8'h00, file_rdata_i = 8'h00, pin_level_i = 8'h55, w_o, wr_data_o;
   logic [6:0] addr_i = 7'h00, wr_addr_o;
   logic [2:0] bit_sel_i = 3'h0;
   logic       carry_o, digit_carry_flag_o, zero_o, wr_en_o, skip_o;
   wire  [7:0] flags_seen   = {5'h00, carry_o, digit_carry_flag_o, zero_o};
   wire  [7:0] strobes_seen = {6'h00, wr_en_o, skip_o};
   int         errors = 0, num_checks = 0, cycles = 0;
   logic [7:0] w_m;
   logic       c_m, dc_m, z_m;
   aab_row_type r;

   // Pin levels stay fixed, so only the pin-backed address sees 8'h55
   aab_row_type rows [18] = '{
      '{ADD_LITERAL_OP, 8'h0f, 7'h00, 1'b0, 3'h0, 8'h00, 8'h0f},
      '{ADD_LITERAL_OP, 8'h01, 7'h00, 1'b0, 3'h0, 8'h00, 8'h10},
      '{ADD_LITERAL_OP, 8'hf0, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00},
      '{ADD_LITERAL_OP, 8'hff, 7'h00, 1'b0, 3'h0, 8'h00, 8'hff},
      '{ADD_REGISTER_OP, 8'h00, 7'h00, 1'b0, 3'h0, 8'h01, 8'h00},
      '{ADD_LITERAL_OP, 8'h3c, 7'h00, 1'b0, 3'h0, 8'h00, 8'h3c},
      '{ADD_REGISTER_OP, 8'h00, 7'h7e, 1'b1, 3'h0, 8'hc8, 8'h04},
      '{AND_REGISTER_OP, 8'h00, 7'h12, 1'b1, 3'h0, 8'hc3, 8'h00},
      '{AND_REGISTER_OP, 8'h00, 7'h13, 1'b0, 3'h0, 8'h0f, 8'h0c},
      '{AND_LITERAL_OP, 8'hf0, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00},
      '{NO_OPERATION, 8'hff, 7'h05, 1'b1, 3'h0, 8'hff, 8'hff},
      '{SKIP_IF_BIT_CLEAR_OP, 8'h00, 7'h40, 1'b0, 3'h3, 8'h08, 8'h00},
      '{SKIP_IF_BIT_SET_OP, 8'h00, 7'h40, 1'b0, 3'h3, 8'h08, 8'h00},
      '{SKIP_IF_BIT_SET_OP, 8'h00, 7'h41, 1'b0, 3'h7, 8'h7f, 8'h00},
      '{SKIP_IF_BIT_CLEAR_OP, 8'h00, 7'h41, 1'b0, 3'h0, 8'hfe, 8'h00},
      '{ADD_LITERAL_OP, 8'hff, 7'h00, 1'b0, 3'h0, 8'h00, 8'hff},
      '{AND_REGISTER_OP, 8'h00, IO_ADDR_DEF, 1'b1, 3'h0, 8'hff, 8'h55},
      '{BIT_SET_OP, 8'h00, IO_ADDR_DEF, 1'b0, 3'h1, 8'h00, 8'h57}};

   aab_exec DUT (.mclk_i, .rst_i, .valid_i, .op_i, .literal_i, .addr_i, .dest_i, .bit_sel_i,
      .file_rdata_i, .pin_level_i, .w_o, .carry_o, .digit_carry_flag_o, .zero_o, .wr_en_o,
      .wr_addr_o, .wr_data_o, .skip_o);

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   // Whole run needs well under a thousand cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic drive(input aab_row_type x);
      @(posedge mclk_i);
      valid_i      <= 1'b1;
      op_i         <= x.op;
      literal_i    <= x.k;
      addr_i       <= x.a;
      dest_i       <= x.d;
      bit_sel_i    <= x.b;
      file_rdata_i <= x.f;
   endtask : drive

   task automatic do_reset();
      @(posedge mclk_i);
      rst_i <= 1'b1;
      #1 check(w_o, ZERO_BYTE, "async clear");
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1 check(w_o, W_RST, "reset accumulator");
      check(flags_seen, 8'h00, "reset flags");
      check(strobes_seen, 8'h00, "reset strobes");
      check({1'b0, wr_addr_o}, 8'h00, "reset address");
      check(wr_data_o, ZERO_BYTE, "reset write data");
      {w_m, c_m, dc_m, z_m} = '0;
   endtask : do_reset

   // Model of the rules; the row supplies the expected result byte
   task automatic exec(input aab_row_type x);
      logic [8:0] sum;
      logic [4:0] nib;
      logic [7:0] opnd;
      logic       lit, reg_op, wen, skp;
      lit    = x.op inside {ADD_LITERAL_OP, AND_LITERAL_OP};
      reg_op = x.op inside {ADD_REGISTER_OP, AND_REGISTER_OP};
      opnd   = lit ? x.k : x.f;
      sum    = {1'b0, w_m} + {1'b0, opnd};
      nib    = {1'b0, w_m[3:0]} + {1'b0, opnd[3:0]};
      wen    = (x.op inside {BIT_CLEAR_OP, BIT_SET_OP}) || (reg_op && x.d);
      skp    = (x.op == SKIP_IF_BIT_CLEAR_OP && !x.f[x.b]) ||
               (x.op == SKIP_IF_BIT_SET_OP && x.f[x.b]);
      if (x.op inside {ADD_LITERAL_OP, ADD_REGISTER_OP}) begin
         c_m  = sum[CARRY_POS];
         dc_m = nib[DC_POS];
      end
      if (lit || reg_op) z_m = (x.res == ZERO_BYTE);
      if (lit || (reg_op && !x.d)) w_m = x.res;
      drive(x);
      @(posedge mclk_i);
      valid_i <= 1'b0;
      #1 check(w_o, w_m, "accumulator");
      check(flags_seen, {5'h00, c_m, dc_m, z_m}, "flags");
      check(strobes_seen, {6'h00, wen, skp}, "strobes");
      if (wen) begin
         check({1'b0, wr_addr_o}, {1'b0, x.a}, "write address");
         check(wr_data_o, x.res, "write data");
      end
   endtask : exec

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      foreach (rows[i]) exec(rows[i]);
      for (int i = 0; i < 8; i++) begin
         r = '{BIT_CLEAR_OP, 8'h00, 7'h30, 1'b0, 3'(i), 8'hff, ~(BIT_ONE << i)};
         exec(r);
         r = '{BIT_SET_OP, 8'h00, 7'h31, 1'b0, 3'(i), 8'h00, BIT_ONE << i};
         exec(r);
      end
      // Back-to-back adds, accumulator starts at 8'hff
      drive('{ADD_LITERAL_OP, 8'h01, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00});
      drive('{ADD_LITERAL_OP, 8'h02, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00});
      @(posedge mclk_i);
      valid_i <= 1'b0;
      #1 check(w_o, 8'h02, "back to back");
      check(flags_seen, 8'h00, "back to back flags");
      // Instruction offered in the discarded slot must leave no trace
      drive('{SKIP_IF_BIT_CLEAR_OP, 8'h00, 7'h22, 1'b0, 3'h0, 8'hfe, 8'h00});
      drive('{ADD_LITERAL_OP, 8'h10, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00});
      #1 check({7'h00, skip_o}, 8'h01, "skip slot");
      @(posedge mclk_i);
      valid_i <= 1'b0;
      #1 check(w_o, 8'h02, "discarded add");
      check(strobes_seen, 8'h00, "slot after skip");
      do_reset();
      exec('{ADD_LITERAL_OP, 8'h01, 7'h00, 1'b0, 3'h0, 8'h00, 8'h01});
      print_verdict();
   end
endmodule : tb_top
